// ===== osi_dev.sv
// device end: decodes frames on the mode/data line, keeps the voltage codes
// assumes line is synchronous to CLOCK_I and pulled up outside
//
// Overview of operation
// - code with select 00 goes to converter 1
// - code with select 10 goes to converter 2
// - bit value from two-to-one duty ratio
// - bit period runs falling edge to falling edge
// - acknowledge on request, matching address, clean frame
// - acknowledge pulls line low at most 520 us
// - pull-down starts after validity delay from last edge
// - host holds line low during validity delay
// - host releases, samples; low means acknowledged
// - bad frame or address: no pull-down
// - no new transaction before acknowledge ends
// - host requests acknowledge only if open drain
// - high line forces pwm at once
// - pwm held throughout frame reception
// - long low abandons decoding, enables power save
// - frame during mode-change timeout is ignored
// - first byte is address 4E, msb first
// - data byte: request, select pair, five-bit code
// - host provides pull-up on shared line
// - host gives start high time before each byte
// - host closes each byte with end-of-stream low
// - active while a converter enabled, ready after 170 us
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module osi_dev #(
   parameter int READY_CYC   = osi_pkg::READY_CYC,
   parameter int ACK_CYC     = osi_pkg::ACK_PULSE_CYC,
   parameter int VALID_CYC   = osi_pkg::ACK_VALID_CYC,
   parameter int TIMEOUT_CYC = osi_pkg::TIMEOUT_CYC
) (
   input  wire logic       CLOCK_I,
   input  wire logic       NRST_I,
   input  wire logic       CONV1_ENABLE_I,
   input  wire logic       CONV2_ENABLE_I,
   osi_link_if.dev         link,
   output logic [4:0]      CONV1_SETTING_O,
   output logic [4:0]      CONV2_SETTING_O,
   output logic            FORCED_PWM_O,
   output logic            READY_O,
   output logic            ACK_ACTIVE_O,
   output logic            FRAME_OK_O,
   output logic            FRAME_BAD_O
);
   import osi_pkg::*;

   osi_dev_state_e     state_q;
   osi_dev_state_e     state_d;
   logic               line_q;
   logic               meas_q;
   logic               meas_d;
   logic               err_q;
   logic               err_d;
   logic [4:0]         bit_cnt_q;
   logic [4:0]         bit_cnt_d;
   logic [FRAME_W-1:0] shift_q;
   logic [FRAME_W-1:0] shift_d;
   logic               psave_q;
   logic [4:0]         conv1_setting_q;
   logic [4:0]         conv2_setting_q;
   logic               ok_q;
   logic               bad_q;
   osi_cnt_t           rdy_q;
   osi_cnt_t           low_q;
   osi_cnt_t           high_q;
   osi_cnt_t           tmo_q;
   osi_cnt_t           tm_q;

   wire             line     = link.line;
   wire             fall     = line_q & ~line;
   wire             active   = CONV1_ENABLE_I | CONV2_ENABLE_I;
   wire             ready    = (rdy_q == osi_cnt_t'(READY_CYC));
   wire             run      = active & ready;
   wire             acking   = (state_q == DEV_ACK);
   wire             cnt_max  = 1'b1;
   wire             timeout  = ~line & ~acking
                               & (tmo_q == osi_cnt_t'(TIMEOUT_CYC - 1));
   wire [CNT_W:0]   low2     = {low_q, 1'b0};
   wire [CNT_W:0]   high2    = {high_q, 1'b0};
   wire             is_one   = ({1'b0, high_q} >= low2);
   wire             is_zero  = ({1'b0, low_q} >= high2);
   wire             bit_ok   = is_one ^ is_zero;
   wire [4:0]       bit_next = bit_cnt_q + 5'h01;
   wire [7:0]       addr_b   = shift_q[FRAME_W-1:BYTE_W];
   wire [7:0]       data_b   = shift_q[BYTE_W-1:0];
   wire             ack_request_bit      = data_b[RFA_BIT];
   wire [1:0]       sel      = data_b[SEL_HI:SEL_LO];
   wire [4:0]       code     = data_b[CODE_MSB:CODE_LSB];
   wire             frame_ok = ~err_q & (addr_b == DEV_ADDR);
   wire             valid_end = (state_q == DEV_VALID)
                               & (tm_q == osi_cnt_t'(VALID_CYC - 1));
   wire             ack_end  = acking & (tm_q == osi_cnt_t'(ACK_CYC - 1));
   wire             load     = valid_end & frame_ok;
   wire             load1    = load & (sel == SEL_CONV1);
   wire             load2    = load & (sel == SEL_CONV2);
   wire             low_sat  = &low_q;
   wire             high_sat = &high_q;

   // bit assembly and frame sequencing
   always_comb begin
      state_d   = state_q;
      meas_d    = meas_q;
      err_d     = err_q;
      bit_cnt_d = bit_cnt_q;
      shift_d   = shift_q;
      case (state_q)
         DEV_RX: begin
            if (timeout) begin
               meas_d    = 1'b0;
               err_d     = 1'b0;
               bit_cnt_d = 5'h00;
            end else if (fall) begin
               if (meas_q) begin
                  shift_d   = {shift_q[FRAME_W-2:0], is_one};
                  err_d     = err_q | ~bit_ok;
                  bit_cnt_d = bit_next;
                  meas_d    = (bit_next != BYTE_BITS)
                              & (bit_next != FRAME_BITS);
                  if (bit_next == FRAME_BITS) begin
                     state_d = DEV_VALID;
                  end
               end else begin
                  meas_d = 1'b1;
               end
            end
         end
         DEV_VALID: begin
            if (valid_end) begin
               meas_d    = 1'b0;
               err_d     = 1'b0;
               bit_cnt_d = 5'h00;
               if (frame_ok & ack_request_bit) begin
                  state_d = DEV_ACK;
               end else begin
                  state_d = DEV_RX;
               end
            end
         end
         DEV_ACK: begin
            if (ack_end) begin
               state_d = DEV_RX;
            end
         end
         default: begin
            state_d = DEV_RX;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_q   <= DEV_RX;
         meas_q    <= 1'b0;
         err_q     <= 1'b0;
         bit_cnt_q <= 5'h00;
         shift_q   <= '0;
      end else if (!run) begin
         state_q   <= DEV_RX;
         meas_q    <= 1'b0;
         err_q     <= 1'b0;
         bit_cnt_q <= 5'h00;
         shift_q   <= '0;
      end else begin
         state_q   <= state_d;
         meas_q    <= meas_d;
         err_q     <= err_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q   <= shift_d;
      end
   end

   // start-up delay after enable
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rdy_q <= '0;
      end else if (!active) begin
         rdy_q <= '0;
      end else if (!ready) begin
         rdy_q <= rdy_q + osi_cnt_t'(cnt_max);
      end
   end

   // low and high time of the running bit
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         line_q <= 1'b1;
         low_q  <= '0;
         high_q <= '0;
      end else begin
         line_q <= line;
         if (fall) begin
            low_q  <= osi_cnt_t'(cnt_max);
            high_q <= '0;
         end else if (!line && !low_sat) begin
            low_q <= low_q + osi_cnt_t'(cnt_max);
         end else if (line && !high_sat) begin
            high_q <= high_q + osi_cnt_t'(cnt_max);
         end
      end
   end

   // low-level timeout; own acknowledge pulse does not count
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         tmo_q <= '0;
      end else if (line || acking) begin
         tmo_q <= '0;
      end else if (tmo_q != osi_cnt_t'(TIMEOUT_CYC)) begin
         tmo_q <= tmo_q + osi_cnt_t'(cnt_max);
      end
   end

   // validity delay and acknowledge length
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         tm_q <= '0;
      end else if (state_q == DEV_RX || valid_end || ack_end) begin
         tm_q <= '0;
      end else begin
         tm_q <= tm_q + osi_cnt_t'(cnt_max);
      end
   end

   // mode: power save only after timeout, pwm as soon as line is high
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         psave_q <= 1'b0;
      end else if (line) begin
         psave_q <= 1'b0;
      end else if (timeout && run) begin
         psave_q <= 1'b1;
      end
   end

   // voltage setting registers
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         conv1_setting_q <= CODE_RST;
         conv2_setting_q <= CODE_RST;
      end else begin
         if (load1) begin
            conv1_setting_q <= code;
         end
         if (load2) begin
            conv2_setting_q <= code;
         end
      end
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ok_q  <= 1'b0;
         bad_q <= 1'b0;
      end else begin
         ok_q  <= load;
         bad_q <= valid_end & ~frame_ok;
      end
   end

   assign link.dev_oe    = acking;
   assign link.dev_dout  = 1'b0;
   assign FORCED_PWM_O   = line | ~psave_q;
   assign READY_O        = run;
   assign ACK_ACTIVE_O   = acking;
   assign FRAME_OK_O     = ok_q;
   assign FRAME_BAD_O    = bad_q;
   assign CONV1_SETTING_O = conv1_setting_q;
   assign CONV2_SETTING_O = conv2_setting_q;
endmodule // osi_dev

// ===== osi_pkg.sv
// constants, field layout, register map and state types of the one-pin link
// assumes a 100 MHz system clock shared by both ends
package osi_pkg;
   localparam int CLK_MHZ       = 100;
   localparam int CNT_W         = 20;
   typedef logic [CNT_W-1:0] osi_cnt_t;

   // device timing
   localparam int READY_US      = 170;
   localparam int READY_CYC     = READY_US * CLK_MHZ;
   localparam int ACK_PULSE_US  = 520;
   localparam int ACK_PULSE_CYC = ACK_PULSE_US * CLK_MHZ;
   localparam int ACK_VALID_US  = 2;
   localparam int ACK_VALID_CYC = ACK_VALID_US * CLK_MHZ;
   localparam int TIMEOUT_US    = 1000;
   localparam int TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;

   // host timing
   localparam int START_US      = 2;
   localparam int START_CYC     = START_US * CLK_MHZ;
   localparam int EOS_US        = 2;
   localparam int EOS_CYC       = EOS_US * CLK_MHZ;
   localparam int ACK_WAIT_US   = 4;
   localparam int ACK_WAIT_CYC  = ACK_WAIT_US * CLK_MHZ;
   localparam int BIT_SHORT_US  = 3;
   localparam int BIT_SHORT_CYC = BIT_SHORT_US * CLK_MHZ;
   localparam int BIT_LONG_US   = 9;
   localparam int BIT_LONG_CYC  = BIT_LONG_US * CLK_MHZ;

   // frame layout
   localparam int         BYTE_W     = 8;
   localparam int         FRAME_W    = 16;
   localparam logic [4:0] BYTE_BITS  = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [7:0] DEV_ADDR   = 8'h4E;
   localparam int         RFA_BIT    = 7;
   localparam int         SEL_HI     = 6;
   localparam int         SEL_LO     = 5;
   localparam int         CODE_MSB   = 4;
   localparam int         CODE_LSB   = 0;
   localparam logic [1:0] SEL_CONV1  = 2'h0;
   localparam logic [1:0] SEL_CONV2  = 2'h2;
   localparam logic [1:0] SEL_RSVD   = 2'h3;
   localparam logic [4:0] CODE_RST   = 5'h00;

   // host register map
   localparam int         APB_AW         = 8;
   localparam logic [7:0] REG_CMD_OFF    = 8'h00;
   localparam logic [7:0] REG_STAT_OFF   = 8'h04;
   localparam logic [7:0] REG_MODE_OFF   = 8'h08;
   localparam int         STAT_BUSY_BIT  = 0;
   localparam int         STAT_ACK_BIT   = 1;
   localparam int         STAT_DONE_BIT  = 2;
   localparam int         MODE_PSAVE_BIT = 0;

   typedef enum {DEV_RX, DEV_VALID, DEV_ACK} osi_dev_state_e;
   typedef enum {H_IDLE, H_START, H_LOW, H_HIGH, H_EOS, H_TAIL, H_SAMPLE,
                 H_WAIT} osi_host_state_e;
endpackage

// ===== osi_link_if.sv
// shared mode/data line with an external pull-up
// assumes both ends are open drain: a driver only pulls low
`timescale 1ns/100ps
interface osi_link_if;
   logic host_dout;
   logic host_oe;
   logic dev_dout;
   logic dev_oe;
   logic line;

   // wired-and with pull-up
   assign line = ~((host_oe & ~host_dout) | (dev_oe & ~dev_dout));

   modport dev  (input line, output dev_dout, output dev_oe);
   modport host (input line, output host_dout, output host_oe);
endinterface

// ===== osi_host.sv
// host end: sends address and data bytes on the mode/data line from apb
// assumes an apb master on CLOCK_I and a pull-up on the line
`timescale 1ns/100ps
module osi_host #(
   parameter int SHORT_CYC = osi_pkg::BIT_SHORT_CYC,
   parameter int LONG_CYC  = osi_pkg::BIT_LONG_CYC,
   parameter int STRT_CYC  = osi_pkg::START_CYC,
   parameter int END_CYC   = osi_pkg::EOS_CYC,
   parameter int WAIT_CYC  = osi_pkg::ACK_WAIT_CYC
) (
   input  wire logic                      CLOCK_I,
   input  wire logic                      NRST_I,
   input  wire logic                      PSEL_I,
   input  wire logic                      PENABLE_I,
   input  wire logic                      PWRITE_I,
   input  wire logic [osi_pkg::APB_AW-1:0] PADDR_I,
   input  wire logic [31:0]               PWDATA_I,
   output logic      [31:0]               PRDATA_O,
   output logic                           PREADY_O,
   output logic                           PSLVERR_O,
   osi_link_if.host                       link
);
   import osi_pkg::*;

   osi_host_state_e    state_q;
   osi_host_state_e    state_d;
   osi_cnt_t           cnt_q;
   osi_cnt_t           lim;
   logic [4:0]         bcnt_q;
   logic [FRAME_W-1:0] sh_q;
   logic [7:0]         cmd_q;
   logic               acked_q;
   logic               done_q;
   logic               psave_q;
   logic [31:0]        prdata_q;

   function automatic osi_cnt_t seg_len(input logic bit_v,
                                        input logic high_ph);
      // a one is short low then long high, a zero the reverse
      seg_len = (bit_v == high_ph) ? osi_cnt_t'(LONG_CYC)
                                   : osi_cnt_t'(SHORT_CYC);
   endfunction

   wire        line     = link.line;
   wire        setup    = PSEL_I & ~PENABLE_I;
   wire        access   = PSEL_I & PENABLE_I;
   wire        hit_cmd  = (PADDR_I == REG_CMD_OFF);
   wire        hit_stat = (PADDR_I == REG_STAT_OFF);
   wire        hit_mode = (PADDR_I == REG_MODE_OFF);
   wire        mapped   = hit_cmd | hit_stat | hit_mode;
   wire        idle     = (state_q == H_IDLE);
   wire        sel_ok   = (PWDATA_I[SEL_HI:SEL_LO] != SEL_RSVD);
   wire        go       = access & PWRITE_I & hit_cmd & idle & sel_ok;
   wire        cur      = sh_q[FRAME_W-1];
   wire [4:0]  bnext    = bcnt_q + 5'h01;
   wire        seg_end  = (cnt_q == lim - osi_cnt_t'(1'b1));
   wire        hi_done  = (state_q == H_HIGH) & seg_end;
   wire [31:0] stat_w   = {29'h0, done_q, acked_q, ~idle};
   wire [31:0] rd_mux   = hit_cmd  ? {24'h0, cmd_q} :
                          hit_stat ? stat_w :
                          hit_mode ? {31'h0, psave_q} : 32'h0;

   always_comb begin
      case (state_q)
         H_START: lim = osi_cnt_t'(STRT_CYC);
         H_LOW:   lim = seg_len(cur, 1'b0);
         H_HIGH:  lim = seg_len(cur, 1'b1);
         H_EOS:   lim = osi_cnt_t'(END_CYC);
         H_TAIL:  lim = osi_cnt_t'(WAIT_CYC);
         default: lim = osi_cnt_t'(1'b1);
      endcase
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         H_IDLE:   if (go) state_d = H_START;
         H_START:  if (seg_end) state_d = H_LOW;
         H_LOW:    if (seg_end) state_d = H_HIGH;
         H_HIGH: begin
            if (seg_end) begin
               if (bnext == BYTE_BITS) begin
                  state_d = H_EOS;
               end else if (bnext == FRAME_BITS) begin
                  state_d = H_TAIL;
               end else begin
                  state_d = H_LOW;
               end
            end
         end
         H_EOS:    if (seg_end) state_d = H_START;
         H_TAIL:   if (seg_end) state_d = H_SAMPLE;
         H_SAMPLE: state_d = H_WAIT;
         H_WAIT:   if (line) state_d = H_IDLE;
         default:  state_d = H_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_q <= H_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= (state_d != state_q) ? '0 : cnt_q + osi_cnt_t'(1'b1);
      end
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         sh_q    <= '0;
         bcnt_q  <= 5'h00;
         cmd_q   <= 8'h00;
         acked_q <= 1'b0;
         done_q  <= 1'b0;
      end else if (go) begin
         sh_q    <= {DEV_ADDR, PWDATA_I[BYTE_W-1:0]};
         cmd_q   <= PWDATA_I[BYTE_W-1:0];
         bcnt_q  <= 5'h00;
         acked_q <= 1'b0;
         done_q  <= 1'b0;
      end else if (hi_done) begin
         sh_q   <= {sh_q[FRAME_W-2:0], 1'b0};
         bcnt_q <= bnext;
      end else if (state_q == H_SAMPLE) begin
         acked_q <= ~line;
      end else if (state_q == H_WAIT && line) begin
         done_q <= 1'b1;
      end
   end

   // apb registers, zero wait states, read data latched in setup
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         psave_q  <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         if (setup) begin
            prdata_q <= rd_mux;
         end
         if (access && PWRITE_I && hit_mode) begin
            psave_q <= PWDATA_I[MODE_PSAVE_BIT];
         end
      end
   end

   // open-drain drive only; the pull-up gives the high level
   assign link.host_oe   = (state_q == H_LOW) | (state_q == H_EOS)
                           | (state_q == H_TAIL)
                           | (idle & psave_q);
   assign link.host_dout = 1'b0;
   assign PRDATA_O       = prdata_q;
   assign PREADY_O       = 1'b1;
   assign PSLVERR_O      = access & ~mapped;
endmodule // osi_host

// ===== osi_link_checker.sv
// assertions on the shared line and the device outputs
// assumes one clock domain, instantiated beside the link interface
`timescale 1ns/100ps
module osi_link_checker #(
   parameter int ACK_CYC     = 50,
   parameter int VALID_CYC   = 5,
   parameter int TIMEOUT_CYC = 2000
) (
   input wire logic       CLOCK_I,
   input wire logic       NRST_I,
   input wire logic       dev_dout,
   input wire logic       dev_oe,
   input wire logic       line,
   input wire logic [4:0] CONV1_SETTING_O,
   input wire logic [4:0] CONV2_SETTING_O,
   input wire logic       FORCED_PWM_O,
   input wire logic       FRAME_OK_O,
   input wire logic       FRAME_BAD_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!NRST_I);
   int low_cnt;
   int ack_cnt;
   int ok_age;
   // low run length, acknowledge length, cycles since accepted frame
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         low_cnt <= 0;
         ack_cnt <= 0;
         ok_age  <= 1000;
      end else begin
         low_cnt <= line ? 0 : (low_cnt < 100000 ? low_cnt + 1 : low_cnt);
         ack_cnt <= dev_oe ? ack_cnt + 1 : 0;
         ok_age  <= FRAME_OK_O ? 0 : (ok_age < 1000 ? ok_age + 1 : ok_age);
      end
   end
   property p_pwm_high;
      line |-> FORCED_PWM_O;
   endproperty
   a_pwm_high: assert property (p_pwm_high) else $error("pwm off on high");
   property p_pwm_frame;
      (!line && low_cnt < TIMEOUT_CYC - 100) |-> FORCED_PWM_O;
   endproperty
   a_pwm_frame: assert property (p_pwm_frame) else $error("pwm lost");
   property p_psave;
      (low_cnt == TIMEOUT_CYC + ACK_CYC + 10) |-> !FORCED_PWM_O;
   endproperty
   a_psave: assert property (p_psave) else $error("no power save");
   property p_ack_delay;
      $rose(dev_oe) |-> low_cnt >= VALID_CYC - 1;
   endproperty
   a_ack_delay: assert property (p_ack_delay) else $error("ack early");
   property p_ack_len;
      dev_oe |-> ack_cnt < ACK_CYC;
   endproperty
   a_ack_len: assert property (p_ack_len) else $error("ack too long");
   property p_ack_exact;
      $fell(dev_oe) |-> ack_cnt == ACK_CYC;
   endproperty
   a_ack_exact: assert property (p_ack_exact) else $error("ack length");
   property p_ack_pull;
      dev_oe |-> !dev_dout && !line;
   endproperty
   a_ack_pull: assert property (p_ack_pull) else $error("ack not low");
   property p_ack_ok;
      $rose(dev_oe) |-> ##[0:2] (ok_age <= VALID_CYC + 6);
   endproperty
   a_ack_ok: assert property (p_ack_ok) else $error("ack no frame");
   property p_set_ok;
      ($changed(CONV1_SETTING_O) || $changed(CONV2_SETTING_O))
         |-> ##[0:2] (ok_age <= 4);
   endproperty
   a_set_ok: assert property (p_set_ok) else $error("stray store");
   property p_bad;
      FRAME_BAD_O |-> !FRAME_OK_O ##1 !dev_oe [*8];
   endproperty
   a_bad: assert property (p_bad) else $error("ack on bad frame");
   c_ack: cover property ($rose(dev_oe));
   c_bad: cover property (FRAME_BAD_O);
   c_psave: cover property (!FORCED_PWM_O);
endmodule // osi_link_checker

// ===== tb.sv
// testbench: host and device joined, second device driven raw
// assumes small timing parameters and a 100 MHz clock
`timescale 1ns/100ps
module tb;
   import osi_pkg::*;
   logic        clk = 0;
   logic        nrst = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0;
   logic [31:0] prdata;
   logic        pready, pslverr, pwm, ready, okp, badp;
   logic [4:0]  c1, c2, d2c1, d2c2;
   logic [31:0] r;
   logic        e;
   logic        en1 = 1'b1;
   logic        en2 = 1'b0;
   logic        ack2;
   localparam int T_SHORT = 4;
   localparam int T_LONG  = 12;
   localparam int T_STRT  = 4;
   localparam int T_END   = 4;
   localparam int T_WAIT  = 10;
   localparam int T_READY = 20;
   localparam int T_ACK   = 50;
   localparam int T_VALID = 5;
   localparam int T_TMO   = 2000;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          seed, e1, e2, f1, f2;
   osi_link_if link();
   osi_link_if link2();
   osi_host #(.SHORT_CYC(T_SHORT), .LONG_CYC(T_LONG), .STRT_CYC(T_STRT),
      .END_CYC(T_END), .WAIT_CYC(T_WAIT)) osi_host_inst (.CLOCK_I(clk),
      .NRST_I(nrst),
      .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .link(link));
   osi_dev #(.READY_CYC(T_READY), .ACK_CYC(T_ACK), .VALID_CYC(T_VALID),
      .TIMEOUT_CYC(T_TMO)) osi_dev_inst (.CLOCK_I(clk), .NRST_I(nrst),
      .CONV1_ENABLE_I(en1), .CONV2_ENABLE_I(en2), .link(link),
      .CONV1_SETTING_O(c1), .CONV2_SETTING_O(c2), .FORCED_PWM_O(pwm),
      .READY_O(ready), .ACK_ACTIVE_O(), .FRAME_OK_O(okp),
      .FRAME_BAD_O(badp));
   osi_dev #(.READY_CYC(T_READY), .ACK_CYC(T_ACK), .VALID_CYC(T_VALID),
      .TIMEOUT_CYC(T_TMO)) osi_dev_inst2 (.CLOCK_I(clk), .NRST_I(nrst),
      .CONV1_ENABLE_I(en2), .CONV2_ENABLE_I(en1), .link(link2),
      .CONV1_SETTING_O(d2c1), .CONV2_SETTING_O(d2c2), .FORCED_PWM_O(),
      .READY_O(), .ACK_ACTIVE_O(ack2), .FRAME_OK_O(), .FRAME_BAD_O());
   osi_link_checker #(.ACK_CYC(T_ACK), .VALID_CYC(T_VALID),
      .TIMEOUT_CYC(T_TMO)) osi_link_checker_inst (.CLOCK_I(clk),
      .NRST_I(nrst),
      .dev_dout(link.dev_dout), .dev_oe(link.dev_oe), .line(link.line),
      .CONV1_SETTING_O(c1), .CONV2_SETTING_O(c2), .FORCED_PWM_O(pwm),
      .FRAME_OK_O(okp), .FRAME_BAD_O(badp));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic end_sim;
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [31:0] x, logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         $display("wrong value %s exp %h got %h", nm, x, g);
         n_fail++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task automatic send(input logic [7:0] b, input logic ign);
      int n;
      n = 0;
      apb(1, REG_CMD_OFF, {24'h0, b});
      r = 1;
      while (r[STAT_BUSY_BIT] !== 1'b0 && n < 3000) begin
         apb(0, REG_STAT_OFF, 0);
         n++;
      end
      if (!ign && b[6:5] == SEL_CONV1) e1 = b[4:0];
      if (!ign && b[6:5] == SEL_CONV2) e2 = b[4:0];
      chk("stat", {29'h0, 1'b1, b[7] & ~ign, 1'b0}, r);
      chk("conv1", e1, {27'h0, c1});
      chk("conv2", e2, {27'h0, c2});
   endtask
   task automatic drv(input logic lo, input int n);
      link2.host_oe <= lo;
      repeat (n) @(posedge clk);
   endtask
   task automatic rcase(input logic [15:0] w, input int bad);
      logic a;
      logic ok;
      logic b2;
      drv(0, 4);
      for (int i = 15; i >= 0; i--) begin
         if (i == 7) begin
            drv(1, 4);
            drv(0, 4);
         end
         if (15 - i == bad) begin
            drv(1, 8);
            drv(0, 8);
         end else begin
            drv(1, w[i] ? 4 : 12);
            drv(0, w[i] ? 12 : 4);
         end
      end
      drv(1, 10);
      drv(0, 2);
      a = ~link2.line;
      b2 = ack2;
      drv(0, 60);
      ok = (w[15:8] == DEV_ADDR) && bad < 0;
      if (ok && w[6:5] == SEL_CONV1) f1 = w[4:0];
      if (ok && w[6:5] == SEL_CONV2) f2 = w[4:0];
      chk("ack2", {31'h0, ok && w[7]}, {31'h0, a});
      chk("ackact", {31'h0, ok && w[7]}, {31'h0, b2});
      chk("d2c1", f1, {27'h0, d2c1});
      chk("d2c2", f2, {27'h0, d2c2});
   endtask
   initial begin
      link2.host_dout = 0;
      link2.host_oe = 0;
      seed = 32'h4CFE;
      e1 = 0;
      e2 = 0;
      f1 = 0;
      f2 = 0;
      repeat (16) @(posedge clk);
      nrst <= 1;
      @(negedge clk);
      chk("ready", 0, {31'h0, ready});
      repeat (25) @(negedge clk);
      chk("ready", 1, {31'h0, ready});
      @(posedge clk);
      en1 <= 1'b0;
      @(posedge clk);
      en1 <= 1'b1;
      @(negedge clk);
      chk("ready", 0, {31'h0, ready});
      repeat (25) @(negedge clk);
      chk("ready", 1, {31'h0, ready});
      @(posedge clk);
      apb(0, 8'h0C, 0);
      chk("unmapped", 1, {31'h0, e});
      rcase({DEV_ADDR, 8'h83}, -1);
      rcase({8'h4F, 8'h85}, -1);
      rcase({DEV_ADDR, 8'hC5}, 4);
      rcase({DEV_ADDR, 8'hE7}, -1);
      rcase({DEV_ADDR, 8'h49}, -1);
      apb(1, REG_MODE_OFF, 1);
      apb(1, REG_MODE_OFF, 0);
      send(8'hD5, 1'b1);
      apb(1, REG_MODE_OFF, 1);
      repeat (2200) @(posedge clk);
      @(negedge clk);
      chk("psave", 0, {31'h0, pwm});
      @(posedge clk);
      apb(1, REG_MODE_OFF, 0);
      repeat (3) @(negedge clk);
      chk("pwm", 1, {31'h0, pwm});
      @(posedge clk);
      for (int k = 0; k < 8; k++) begin
         r = $random(seed);
         send({r[7:6], 1'b0, r[4:0]}, 1'b0);
      end
      apb(1, REG_CMD_OFF, 32'h0000_00E3);
      apb(0, REG_STAT_OFF, 0);
      chk("refused", 0, {31'h0, r[STAT_BUSY_BIT]});
      end_sim();
   end
endmodule // tb
